// file: core/shbp_device.sv
// Device end of the SRAM-style host port
module shbp_device
  import shbp_pkg::*;
#(
  parameter int TMR_W = 16
)(
  input wire logic clk, // 20 MHz clock
  input wire logic rst_b, // Async reset
  shbp_if.dev bus, // Host pins
  input wire logic bus_width_strap, // High selects 32-bit bus
  input wire logic speed_sel_strap, // High selects 100 Mb/s
  input wire logic [DW-1:0] csr_rdata, // Register read word
  input wire logic [DW-1:0] rx_rdata, // Receive FIFO word
  input wire logic wake_frame, // Wake frame seen
  input wire logic link_change, // Link status changed
  input wire logic wake_packet, // Special wake packet seen
  input wire logic ext_event, // Other interrupt source
  output logic csr_rd, // Register read pulse
  output logic csr_wr, // Register write pulse
  output logic [5:0] csr_idx, // Register word index
  output logic [DW-1:0] csr_wdata, // Register write word
  output logic rx_rd, // Receive FIFO pop
  output logic tx_wr, // Transmit FIFO push
  output logic [DW-1:0] tx_wdata, // Transmit FIFO word
  output logic cfg_speed_100, // Default speed 100
  output logic cfg_autoneg_en, // Default autonegotiation
  output logic bus_wide, // 32-bit bus in use
  output logic low_power // Reduced power state
);
  logic strap_done_reg, wide_reg, spd_reg, pd_reg;
  logic rd_prev_reg, wr_prev_reg;
  logic rd_now, wr_now, rd_go, wr_go, wake_wr;
  logic [5:0] idx;
  logic hsel, is_rx, is_tx, is_own, wr_full, own_wr;
  logic [HW-1:0] half_lo_reg;
  logic [DW-1:0] wr_word, csr_word;
  logic csr_rd_reg, csr_wr_reg, rx_rd_reg, tx_wr_reg;
  logic [5:0] csr_idx_reg, rd_idx_reg;
  logic [DW-1:0] csr_wdata_reg, tx_wdata_reg;
  logic rd_pend_reg, rd_hsel_reg;
  shbp_rkind_t rd_kind_reg;
  logic [DW-1:0] own_rdata, src_word, steer_word, steer_bus, word_reg, dout_reg;
  logic dout_oe_reg, swap_rd;
  logic [2:0] irq_cfg_reg;
  logic [NINT-1:0] int_en_reg, int_sts_reg, int_evt, int_clr;
  logic low_reg, pwr_evt_reg;
  logic [NWAKE-1:0] wen_reg;
  logic tmr_en_reg, tmr_evt, wake_evt, irq_act;
  logic [TMR_W-1:0] tmr_rld_reg, tmr_cnt_reg;
  logic irq_o_reg, irq_oe_reg;

  // Qualified strobes and their leading edges
  assign rd_now = !bus.chip_select_low && !bus.read_strobe_low;
  assign wr_now = !bus.chip_select_low && !bus.write_strobe_low && bus.read_strobe_low;
  assign rd_go = rd_now && !rd_prev_reg && !low_reg;
  assign wr_go = wr_now && !wr_prev_reg && !low_reg;
  assign wake_wr = wr_now && !wr_prev_reg && low_reg;

  // Address decode
  always_comb
  begin
    if (bus.fifo_sel)
      idx = rd_now ? IDX_RX_LO : IDX_TX_LO;
    else
      idx = bus.addr[7:2];
    hsel = !wide_reg && bus.addr[1];
    is_rx = idx < IDX_TX_LO;
    is_tx = !is_rx && idx < IDX_CSR_LO;
    is_own = idx >= IDX_IRQ_CFG && idx <= IDX_TIMER;
  end

  // Write word assembly and register-path reorder
  assign wr_word = wide_reg ? bus.data : {bus.data[HW-1:0], half_lo_reg};
  assign wr_full = wide_reg || hsel;
  assign csr_word = irq_cfg_reg[BIG_END_BIT] ? shbp_swap32(wr_word) : wr_word;
  assign own_wr = wr_go && wr_full && is_own;

  // Strobe history
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end
    else
    begin
      rd_prev_reg <= rd_now;
      wr_prev_reg <= wr_now;
    end
  end

  // Strap capture at first edge after reset release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_done_reg <= 1'b0;
      wide_reg <= 1'b0;
      spd_reg <= 1'b0;
      pd_reg <= 1'b1;
    end
    else if (!strap_done_reg)
    begin
      strap_done_reg <= 1'b1;
      wide_reg <= bus_width_strap;
      spd_reg <= speed_sel_strap;
      pd_reg <= !bus_width_strap;
    end
  end

  // Internal access issue
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      csr_rd_reg <= 1'b0;
      csr_wr_reg <= 1'b0;
      rx_rd_reg <= 1'b0;
      tx_wr_reg <= 1'b0;
      csr_idx_reg <= IDX_RX_LO;
      csr_wdata_reg <= ZERO_WORD;
      tx_wdata_reg <= ZERO_WORD;
      half_lo_reg <= ZERO_HALF;
      rd_pend_reg <= 1'b0;
      rd_hsel_reg <= 1'b0;
      rd_idx_reg <= IDX_RX_LO;
      rd_kind_reg <= RK_EXT;
    end
    else
    begin
      csr_rd_reg <= 1'b0;
      csr_wr_reg <= 1'b0;
      rx_rd_reg <= 1'b0;
      tx_wr_reg <= 1'b0;
      rd_pend_reg <= rd_go;
      if (wr_go && !wr_full)
        half_lo_reg <= bus.data[HW-1:0];
      else if (wr_go && is_tx)
      begin
        tx_wr_reg <= 1'b1;
        tx_wdata_reg <= wr_word;
      end
      else if (wr_go && !is_rx && !is_own)
      begin
        csr_wr_reg <= 1'b1;
        csr_idx_reg <= idx;
        csr_wdata_reg <= csr_word;
      end
      if (rd_go)
      begin
        rd_hsel_reg <= hsel;
        rd_idx_reg <= idx;
        if (hsel)
          rd_kind_reg <= RK_LATCH;
        else if (is_rx)
        begin
          rd_kind_reg <= RK_RX;
          rx_rd_reg <= 1'b1;
        end
        else if (is_tx || is_own)
          rd_kind_reg <= RK_OWN;
        else
        begin
          rd_kind_reg <= RK_EXT;
          csr_rd_reg <= 1'b1;
          csr_idx_reg <= idx;
        end
      end
    end
  end

  // Own register read mux
  always_comb
  begin
    own_rdata = ZERO_WORD;
    if (rd_idx_reg == IDX_IRQ_CFG)
      own_rdata[2:0] = irq_cfg_reg;
    else if (rd_idx_reg == IDX_INT_STS)
      own_rdata[NINT-1:0] = int_sts_reg;
    else if (rd_idx_reg == IDX_INT_EN)
      own_rdata[NINT-1:0] = int_en_reg;
    else if (rd_idx_reg == IDX_PM_CTRL)
      own_rdata[NWAKE:0] = {wen_reg, low_reg};
    else if (rd_idx_reg == IDX_TIMER)
    begin
      own_rdata[TMR_W-1:0] = tmr_rld_reg;
      own_rdata[TMR_EN_BIT] = tmr_en_reg;
    end
  end

  // Read word source
  always_comb
  begin
    swap_rd = irq_cfg_reg[BIG_END_BIT];
    case (rd_kind_reg)
      RK_RX:
      begin
        src_word = rx_rdata;
        swap_rd = 1'b0;
      end
      RK_OWN: src_word = own_rdata;
      RK_LATCH:
      begin
        src_word = word_reg;
        swap_rd = 1'b0;
      end
      default: src_word = csr_rdata;
    endcase
  end

  shbp_lane_steer u_steer (
    .word(src_word),
    .swap_en(swap_rd),
    .wide(wide_reg),
    .hsel(rd_hsel_reg),
    .word_out(steer_word),
    .bus_out(steer_bus)
  );

  // Read data drive
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      word_reg <= ZERO_WORD;
      dout_reg <= ZERO_WORD;
      dout_oe_reg <= 1'b0;
    end
    else
    begin
      dout_oe_reg <= rd_now && !low_reg;
      if (rd_pend_reg)
      begin
        word_reg <= steer_word;
        dout_reg <= steer_bus;
      end
    end
  end

  // Interrupt configuration and source enables
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_cfg_reg <= 3'h0;
      int_en_reg <= 3'h0;
    end
    else if (own_wr && idx == IDX_IRQ_CFG)
      irq_cfg_reg <= csr_word[2:0];
    else if (own_wr && idx == IDX_INT_EN)
      int_en_reg <= csr_word[NINT-1:0];
  end

  // Sticky status, set wins over write-one clear
  assign wake_evt = |({wake_packet, link_change, wake_frame} & wen_reg);
  assign tmr_evt = tmr_en_reg && tmr_cnt_reg == '0;
  assign int_evt = {ext_event, wake_evt, tmr_evt};
  assign int_clr = (own_wr && idx == IDX_INT_STS) ? csr_word[NINT-1:0] : 3'h0;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      int_sts_reg <= 3'h0;
    else
      int_sts_reg <= (int_sts_reg & ~int_clr) | int_evt;
  end

  // Power state and wake indication
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_reg <= 1'b0;
      wen_reg <= 3'h0;
      pwr_evt_reg <= 1'b0;
    end
    else
    begin
      if (wake_wr)
        low_reg <= 1'b0;
      else if (own_wr && idx == IDX_PM_CTRL)
      begin
        low_reg <= csr_word[PM_LOW_BIT];
        wen_reg <= csr_word[PM_WEN_LSB +: NWAKE];
      end
      if (wake_evt)
        pwr_evt_reg <= 1'b1;
      else if (wake_wr)
        pwr_evt_reg <= 1'b0;
    end
  end

  // General timer, reloads and flags on reaching zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tmr_en_reg <= 1'b0;
      tmr_rld_reg <= '0;
      tmr_cnt_reg <= '0;
    end
    else if (own_wr && idx == IDX_TIMER)
    begin
      tmr_en_reg <= csr_word[TMR_EN_BIT];
      tmr_rld_reg <= csr_word[TMR_W-1:0];
      tmr_cnt_reg <= csr_word[TMR_W-1:0];
    end
    else if (!tmr_en_reg || tmr_evt)
      tmr_cnt_reg <= tmr_rld_reg;
    else
      tmr_cnt_reg <= tmr_cnt_reg - 1'b1;
  end

  // Interrupt pin with polarity and buffer type
  assign irq_act = |(int_sts_reg & int_en_reg);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_o_reg <= 1'b0;
      irq_oe_reg <= 1'b0;
    end
    else if (irq_cfg_reg[IRQ_OD_BIT])
    begin
      irq_o_reg <= 1'b0;
      irq_oe_reg <= irq_act;
    end
    else
    begin
      irq_o_reg <= irq_cfg_reg[IRQ_POL_BIT] ? irq_act : !irq_act;
      irq_oe_reg <= 1'b1;
    end
  end

  // Outputs
  assign bus.d_do = dout_reg;
  assign bus.d_oe = dout_oe_reg;
  assign bus.pd_hi_en = pd_reg;
  assign bus.irq_o = irq_o_reg;
  assign bus.irq_oe = irq_oe_reg;
  assign bus.power_event_out = pwr_evt_reg;
  assign csr_rd = csr_rd_reg;
  assign csr_wr = csr_wr_reg;
  assign csr_idx = csr_idx_reg;
  assign csr_wdata = csr_wdata_reg;
  assign rx_rd = rx_rd_reg;
  assign tx_wr = tx_wr_reg;
  assign tx_wdata = tx_wdata_reg;
  assign cfg_speed_100 = spd_reg;
  assign cfg_autoneg_en = spd_reg;
  assign bus_wide = wide_reg;
  assign low_power = low_reg;
endmodule

// file: core/shbp_pkg.sv
// Shared constants, types and helpers for the SRAM-style host port
package shbp_pkg;
  localparam int DW = 32;
  localparam int HW = 16;
  localparam int NINT = 3;
  localparam int NWAKE = 3;
  // Word index map seen through the host port (index = A[7:2])
  localparam logic [5:0] IDX_RX_LO = 6'h00;
  localparam logic [5:0] IDX_TX_LO = 6'h08;
  localparam logic [5:0] IDX_CSR_LO = 6'h10;
  localparam logic [5:0] IDX_IRQ_CFG = 6'h15;
  localparam logic [5:0] IDX_INT_STS = 6'h16;
  localparam logic [5:0] IDX_INT_EN = 6'h17;
  localparam logic [5:0] IDX_PM_CTRL = 6'h18;
  localparam logic [5:0] IDX_TIMER = 6'h19;
  // Field positions of the device's own registers
  localparam int IRQ_POL_BIT = 0;
  localparam int IRQ_OD_BIT = 1;
  localparam int BIG_END_BIT = 2;
  localparam int INT_TMR_BIT = 0;
  localparam int INT_WAKE_BIT = 1;
  localparam int INT_EXT_BIT = 2;
  localparam int PM_LOW_BIT = 0;
  localparam int PM_WEN_LSB = 1;
  localparam int TMR_EN_BIT = 31;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [15:0] ZERO_HALF = 16'h0000;
  // Host controller command registers (Avalon word address)
  localparam logic [2:0] HA_ADDR = 3'h0;
  localparam logic [2:0] HA_WDATA = 3'h1;
  localparam logic [2:0] HA_CMD = 3'h2;
  localparam logic [2:0] HA_RDATA = 3'h3;
  localparam logic [2:0] HA_STS = 3'h4;
  localparam logic [2:0] HA_MASK = 3'h5;
  localparam int AD_FSEL_BIT = 6;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_WR_BIT = 1;
  localparam int CMD_WIDE_BIT = 2;
  localparam int CMD_IRQ_HI_BIT = 3;
  localparam int CMD_BUSY_BIT = 31;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int ST_PWR_EVT_BIT = 2;
  // Host strobe timing at the 50 ns clock
  localparam int CLK_NS = 50;
  localparam int STROBE_NS = 200;
  localparam int RECOV_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC = (RECOV_NS + CLK_NS - 1) / CLK_NS;
  // Source of a pending read word
  typedef enum logic [1:0] {RK_EXT, RK_RX, RK_OWN, RK_LATCH} shbp_rkind_t;
  // Host cycle sequencer states
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_SETUP = 4'h2,
    HS_STROBE = 4'h4,
    HS_RECOV = 4'h8
  } shbp_hstate_t;
  // Byte lane reversal for big-endian hosts
  function automatic logic [31:0] shbp_swap32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
endpackage

// file: core/shbp_if.sv
// Pin-level carrier between host controller and device port
interface shbp_if;
  import shbp_pkg::*;
  logic [7:1] addr;
  logic read_strobe_low;
  logic write_strobe_low;
  logic chip_select_low;
  logic fifo_sel;
  logic [DW-1:0] h_do;
  logic h_oe;
  logic [DW-1:0] d_do;
  logic d_oe;
  logic pd_hi_en;
  logic irq_o;
  logic irq_oe;
  logic power_event_out;
  logic [DW-1:0] data;
  logic irq_line;
  // Resolved data wire; released lanes lose the last value, upper ones pulled low if enabled
  assign data = d_oe ? d_do : h_oe ? h_do :
                {(pd_hi_en ? ZERO_HALF : ~h_do[DW-1:HW]), ~h_do[HW-1:0]};
  // Interrupt wire with a board pull-up for open-drain use
  assign irq_line = irq_oe ? irq_o : 1'b1;
  modport dev (
    input addr, read_strobe_low, write_strobe_low, chip_select_low, fifo_sel, data,
    output d_do, d_oe, pd_hi_en, irq_o, irq_oe, power_event_out
  );
  modport host (
    output addr, read_strobe_low, write_strobe_low, chip_select_low, fifo_sel, h_do, h_oe,
    input data, irq_line, power_event_out
  );
endinterface

// file: core/shbp_lane_steer.sv
// Read-side byte reorder and halfword lane steering
module shbp_lane_steer
  import shbp_pkg::*;
(
  input wire logic [DW-1:0] word, // Internal word
  input wire logic swap_en, // Reverse byte lanes
  input wire logic wide, // 32-bit bus
  input wire logic hsel, // Upper halfword wanted
  output logic [DW-1:0] word_out, // Word after reorder
  output logic [DW-1:0] bus_out // Lanes for the bus
);
  // Reorder, then pick lanes
  always_comb
  begin
    word_out = swap_en ? shbp_swap32(word) : word;
    if (wide)
      bus_out = word_out;
    else if (hsel)
      bus_out = {ZERO_HALF, word_out[DW-1:HW]};
    else
      bus_out = {ZERO_HALF, word_out[HW-1:0]};
  end
endmodule

// file: core/shbp_host.sv
// Host end: runs port cycles ordered over Avalon-MM
module shbp_host
  import shbp_pkg::*;
(
  input wire logic clk, // 20 MHz clock
  input wire logic rst_b, // Async reset
  shbp_if.host bus, // Device pins
  input wire logic [2:0] av_address, // Word address
  input wire logic av_read, // Read request
  input wire logic av_write, // Write request
  input wire logic [DW-1:0] av_writedata, // Write data
  output logic [DW-1:0] av_readdata, // Read data
  output logic av_waitrequest, // Stall
  output logic irq // Unmasked status pending
);
  shbp_hstate_t st_reg;
  logic [2:0] cnt_reg, sts_reg, mask_reg, sts_evt, sts_clr;
  logic [6:0] addr_reg;
  logic [DW-1:0] wdata_reg, rdata_reg, rdd_reg, do_reg;
  logic dir_wr_reg, wide_reg, irq_hi_reg, busy_reg, half_reg, wait_reg, irq_reg;
  logic cs_reg, rd_reg, wr_reg, oe_reg, fsel_reg, done_evt, av_wr, go;
  logic [7:1] a_reg;

  // Lanes for one bus cycle
  function automatic logic [DW-1:0] lanes(input logic [DW-1:0] w, input logic wide,
                                          input logic hi);
    if (wide)
      return w;
    return {ZERO_HALF, (hi ? w[DW-1:HW] : w[HW-1:0])};
  endfunction

  assign av_wr = av_write && !wait_reg;
  assign go = av_wr && av_address == HA_CMD && av_writedata[CMD_GO_BIT] && !busy_reg;
  assign done_evt = st_reg == HS_RECOV && cnt_reg == 3'h0 && (wide_reg || half_reg);

  // Avalon handshake, one wait cycle per access
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wait_reg <= 1'b1;
      rdd_reg <= ZERO_WORD;
    end
    else
    begin
      wait_reg <= !((av_read || av_write) && wait_reg);
      if (av_read && wait_reg)
      begin
        if (av_address == HA_ADDR)
          rdd_reg <= {25'h000_0000, addr_reg};
        else if (av_address == HA_WDATA)
          rdd_reg <= wdata_reg;
        else if (av_address == HA_CMD)
          rdd_reg <= {busy_reg, 27'h000_0000, irq_hi_reg, wide_reg, dir_wr_reg, 1'b0};
        else if (av_address == HA_RDATA)
          rdd_reg <= rdata_reg;
        else if (av_address == HA_STS)
          rdd_reg <= {29'h0000_0000, sts_reg};
        else if (av_address == HA_MASK)
          rdd_reg <= {29'h0000_0000, mask_reg};
        else
          rdd_reg <= ZERO_WORD;
      end
    end
  end

  // Command set-up registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_reg <= 7'h00;
      wdata_reg <= ZERO_WORD;
      dir_wr_reg <= 1'b0;
      wide_reg <= 1'b0;
      irq_hi_reg <= 1'b0;
      mask_reg <= 3'h0;
    end
    else if (av_wr)
    begin
      if (av_address == HA_ADDR)
        addr_reg <= av_writedata[6:0];
      else if (av_address == HA_WDATA)
        wdata_reg <= av_writedata;
      else if (av_address == HA_MASK)
        mask_reg <= av_writedata[2:0];
      else if (go)
      begin
        dir_wr_reg <= av_writedata[CMD_WR_BIT];
        wide_reg <= av_writedata[CMD_WIDE_BIT];
        irq_hi_reg <= av_writedata[CMD_IRQ_HI_BIT];
      end
    end
  end

  // Sticky status, set wins over write-one clear
  assign sts_evt = {bus.power_event_out, bus.irq_line == irq_hi_reg, done_evt};
  assign sts_clr = (av_wr && av_address == HA_STS) ? av_writedata[2:0] : 3'h0;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sts_reg <= 3'h0;
      irq_reg <= 1'b0;
    end
    else
    begin
      sts_reg <= (sts_reg & ~sts_clr) | sts_evt;
      irq_reg <= |(sts_reg & mask_reg);
    end
  end

  // Port cycle sequencer
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_reg <= HS_IDLE;
      cnt_reg <= 3'h0;
      half_reg <= 1'b0;
      busy_reg <= 1'b0;
      cs_reg <= 1'b1;
      rd_reg <= 1'b1;
      wr_reg <= 1'b1;
      oe_reg <= 1'b0;
      fsel_reg <= 1'b0;
      a_reg <= 7'h00;
      do_reg <= ZERO_WORD;
      rdata_reg <= ZERO_WORD;
    end
    else
    begin
      case (st_reg)
        HS_IDLE:
          if (go)
          begin
            busy_reg <= 1'b1;
            half_reg <= 1'b0;
            cs_reg <= 1'b0;
            fsel_reg <= addr_reg[AD_FSEL_BIT];
            a_reg <= {addr_reg[5:0], 1'b0};
            do_reg <= lanes(wdata_reg, av_writedata[CMD_WIDE_BIT], 1'b0);
            oe_reg <= av_writedata[CMD_WR_BIT];
            st_reg <= HS_SETUP;
          end
        HS_SETUP:
        begin
          rd_reg <= dir_wr_reg;
          wr_reg <= !dir_wr_reg;
          cnt_reg <= 3'(STROBE_CYC - 1);
          st_reg <= HS_STROBE;
        end
        HS_STROBE:
          if (cnt_reg == 3'h0)
          begin
            if (!dir_wr_reg && wide_reg)
              rdata_reg <= bus.data;
            else if (!dir_wr_reg && half_reg)
              rdata_reg[DW-1:HW] <= bus.data[HW-1:0];
            else if (!dir_wr_reg)
              rdata_reg[HW-1:0] <= bus.data[HW-1:0];
            rd_reg <= 1'b1;
            wr_reg <= 1'b1;
            cs_reg <= 1'b1;
            oe_reg <= 1'b0;
            cnt_reg <= 3'(RECOV_CYC - 1);
            st_reg <= HS_RECOV;
          end
          else
            cnt_reg <= cnt_reg - 1'b1;
        HS_RECOV:
          if (cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 1'b1;
          else if (!wide_reg && !half_reg)
          begin
            half_reg <= 1'b1;
            cs_reg <= 1'b0;
            a_reg <= {addr_reg[5:0], 1'b1};
            do_reg <= lanes(wdata_reg, 1'b0, 1'b1);
            oe_reg <= dir_wr_reg;
            st_reg <= HS_SETUP;
          end
          else
          begin
            busy_reg <= 1'b0;
            st_reg <= HS_IDLE;
          end
        default: st_reg <= HS_IDLE;
      endcase
    end
  end

  // Outputs
  assign bus.addr = a_reg;
  assign bus.chip_select_low = cs_reg;
  assign bus.read_strobe_low = rd_reg;
  assign bus.write_strobe_low = wr_reg;
  assign bus.fifo_sel = fsel_reg;
  assign bus.h_do = do_reg;
  assign bus.h_oe = oe_reg;
  assign av_readdata = rdd_reg;
  assign av_waitrequest = wait_reg;
  assign irq = irq_reg;
endmodule

// file: verif/shbp_monitor.sv
// Pin-level checks on the host port carrier
module shbp_monitor
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic [7:1] addr, // Address
  input wire logic read_strobe_low, // Read strobe
  input wire logic write_strobe_low, // Write strobe
  input wire logic chip_select_low, // Select
  input wire logic h_oe, // Host drives
  input wire logic d_oe, // Device drives
  input wire logic pd_hi_en, // Pull-downs on
  input wire logic power_event_out // Wake event
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Some strobe is active
  logic acc;
  assign acc = !(read_strobe_low && write_strobe_low);
  // Data ownership, strobe framing, straps, wake
  oe_cause_a: assert property (d_oe |-> $past(!chip_select_low && !read_strobe_low))
    else $error("data driven without read");
  oe_drop_a: assert property ((read_strobe_low || chip_select_low) |=> !d_oe)
    else $error("data held after release");
  cs_qual_a: assert property (acc |-> !chip_select_low)
    else $error("strobe without select");
  one_dir_a: assert property (!(h_oe && d_oe) && (read_strobe_low || write_strobe_low))
    else $error("bus fight");
  addr_hold_a: assert property (acc && $past(acc) |-> $stable(addr))
    else $error("address moved in strobe");
  rd_len_a: assert property ($fell(read_strobe_low) |-> (!read_strobe_low) [*4] ##1 read_strobe_low)
    else $error("read strobe length");
  recov_a: assert property ($rose(read_strobe_low) || $rose(write_strobe_low) |=> !acc)
    else $error("no recovery");
  pd_keep_a: assert property ($past(rst_b, 2) |-> $stable(pd_hi_en))
    else $error("width changed in run");
  wake_clr_a: assert property (!chip_select_low && $fell(write_strobe_low) |-> ##[0:3] !power_event_out)
    else $error("write did not wake");
  // Main scenarios seen
  cover property ($rose(d_oe));
  cover property ($rose(power_event_out));
  cover property ($fell(pd_hi_en));
endmodule

// file: verif/tb.sv
// Bench joining host and device ends of the port
`define CK(a, b) \
  begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end
module tb
  import shbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CSR_V = 32'h1234_5678;
  localparam logic [31:0] RX_V = 32'h5A5A_3C3C;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic bws = 1'h1;
  logic sps = 1'h1;
  logic ext = 1'h0;
  logic wd = 1'h1;
  logic [2:0] ev = 3'h0;
  logic [2:0] av_address = 3'h0;
  logic av_read = 1'h0;
  logic av_write = 1'h0;
  logic [31:0] av_writedata = 32'h0, av_readdata, csr_wdata, tx_wdata, rdv, wdt, txd;
  logic [5:0] csr_idx, wi;
  logic csr_rd, csr_wr, rx_rd, tx_wr, cfg_speed_100, cfg_autoneg_en, bus_wide;
  logic low_power, irq, av_waitrequest;
  int err_total = 0, num_checks = 0, ncw = 0, ncr = 0, nrx = 0, ntx = 0;
  shbp_if shbp_if_i ();
  shbp_device shbp_device_i (.clk, .rst_b, .bus(shbp_if_i.dev), .bus_width_strap(bws),
    .speed_sel_strap(sps), .csr_rdata(CSR_V), .rx_rdata(RX_V), .wake_frame(ev[0]),
    .link_change(ev[1]), .wake_packet(ev[2]), .ext_event(ext), .csr_rd, .csr_wr, .csr_idx,
    .csr_wdata, .rx_rd, .tx_wr, .tx_wdata, .cfg_speed_100, .cfg_autoneg_en, .bus_wide,
    .low_power);
  shbp_host shbp_host_i (.clk, .rst_b, .bus(shbp_if_i.host), .av_address, .av_read,
    .av_write, .av_writedata, .av_readdata, .av_waitrequest, .irq);
  shbp_monitor shbp_monitor_i (.clk, .rst_b, .addr(shbp_if_i.addr),
    .read_strobe_low(shbp_if_i.read_strobe_low), .write_strobe_low(shbp_if_i.write_strobe_low),
    .chip_select_low(shbp_if_i.chip_select_low), .h_oe(shbp_if_i.h_oe), .d_oe(shbp_if_i.d_oe),
    .pd_hi_en(shbp_if_i.pd_hi_en), .power_event_out(shbp_if_i.power_event_out));
  // Clock
  always #25 clk = ~clk;
  // Device-side access log
  always @(posedge clk)
  begin
    ncw <= ncw + csr_wr;
    ncr <= ncr + csr_rd;
    nrx <= nrx + rx_rd;
    ntx <= ntx + tx_wr;
    if (csr_wr) wdt <= csr_wdata;
    if (csr_wr) wi <= csr_idx;
    if (tx_wr) txd <= tx_wdata;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // One Avalon transfer, held until waitrequest is low
  task automatic av(input logic [2:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    av_address <= a;
    av_write <= w;
    av_read <= !w;
    av_writedata <= d;
    do @(posedge clk); while (av_waitrequest !== 1'h0);
    rdv = av_readdata;
    av_write <= 1'h0;
    av_read <= 1'h0;
  endtask
  // One word access ordered through the host end, two pin cycles on a 16-bit bus
  task automatic pio(input logic [6:0] ad, input logic w, input logic [31:0] d);
    av(HA_ADDR, 1'h1, {25'h0, ad});
    av(HA_WDATA, 1'h1, d);
    av(HA_CMD, 1'h1, {28'h0, 1'h1, wd, w, 1'h1});
    do av(HA_CMD, 1'h0, 32'h0); while (rdv[CMD_BUSY_BIT] !== 1'h0);
    av(HA_RDATA, 1'h0, 32'h0);
  endtask
  task automatic t_strap(input logic w, input logic s);
    @(posedge clk);
    rst_b <= 1'h0;
    bws <= w;
    sps <= s;
    repeat (20) @(posedge clk);
    rst_b <= 1'h1;
    repeat (3) @(negedge clk);
    `CK(bus_wide, w)
    `CK(shbp_if_i.pd_hi_en, !w)
    `CK(cfg_speed_100, s)
    `CK(cfg_autoneg_en, s)
    wd = w;
  endtask
  task automatic t_csr();
    int n;
    n = ncw;
    pio(7'h20, 1'h1, 32'hA5A5_0F0F);
    `CK(ncw, n + 1)
    `CK(wi, 6'h20)
    `CK(wdt, 32'hA5A5_0F0F)
    pio(7'h20, 1'h0, 32'h0);
    `CK(rdv, CSR_V)
  endtask
  task automatic t_fifo();
    int n, m;
    n = ntx;
    m = nrx;
    pio(7'h7F, 1'h1, 32'h0BAD_F00D);
    `CK(ntx, n + 1)
    `CK(txd, 32'h0BAD_F00D)
    pio(7'h7F, 1'h0, 32'h0);
    `CK(rdv, RX_V)
    pio(7'h02, 1'h0, 32'h0);
    `CK(rdv, RX_V)
    `CK(nrx, m + 2)
  endtask
  task automatic t_endian();
    pio(7'h15, 1'h1, 32'h0000_0004);
    pio(7'h20, 1'h1, 32'h1122_3344);
    `CK(wdt, 32'h4433_2211)
    pio(7'h20, 1'h0, 32'h0);
    `CK(rdv, 32'h7856_3412)
    pio(7'h15, 1'h1, 32'h0);
  endtask
  task automatic t_irq();
    pio(7'h17, 1'h1, 32'h0000_0004);
    pio(7'h15, 1'h1, 32'h0000_0001);
    av(HA_STS, 1'h1, 32'h0000_0002);
    av(HA_MASK, 1'h1, 32'h0000_0002);
    repeat (2) @(negedge clk);
    `CK(irq, 1'h0)
    @(posedge clk);
    ext <= 1'h1;
    @(posedge clk);
    ext <= 1'h0;
    repeat (4) @(negedge clk);
    `CK(shbp_if_i.irq_line, 1'h1)
    `CK(irq, 1'h1)
    av(HA_MASK, 1'h1, 32'h0);
    repeat (2) @(negedge clk);
    `CK(irq, 1'h0)
    pio(7'h15, 1'h1, 32'h0000_0002);
    `CK(shbp_if_i.irq_line, 1'h0)
    pio(7'h16, 1'h1, 32'h0000_0004);
    `CK(shbp_if_i.irq_oe, 1'h0)
    pio(7'h15, 1'h1, 32'h0000_0001);
    av(HA_STS, 1'h1, 32'h0000_0002);
    av(HA_MASK, 1'h1, 32'h0000_0002);
    repeat (2) @(negedge clk);
    `CK(irq, 1'h0)
  endtask
  task automatic t_timer();
    pio(7'h19, 1'h1, 32'h8000_0009);
    repeat (30) @(posedge clk);
    pio(7'h19, 1'h1, 32'h0);
    pio(7'h16, 1'h0, 32'h0);
    `CK(rdv[INT_TMR_BIT], 1'h1)
    pio(7'h16, 1'h1, 32'h0000_0001);
    pio(7'h16, 1'h0, 32'h0);
    `CK(rdv[INT_TMR_BIT], 1'h0)
  endtask
  task automatic t_wake();
    int n;
    for (int k = 0; k < 3; k++)
    begin
      pio(7'h18, 1'h1, 32'h1 | (32'h2 << k));
      `CK(low_power, 1'h1)
      @(posedge clk);
      ev <= 3'h1 << k;
      @(posedge clk);
      ev <= 3'h0;
      repeat (3) @(negedge clk);
      `CK(shbp_if_i.power_event_out, 1'h1)
      n = ncr;
      pio(7'h20, 1'h0, 32'h0);
      `CK(ncr, n)
      pio(7'h20, 1'h1, 32'h0);
      `CK(low_power, 1'h0)
      `CK(shbp_if_i.power_event_out, 1'h0)
    end
  endtask
  // Watchdog
  initial
  begin
    #500_000;
    err_total++;
    close_out();
  end
  // Main sequence
  initial
  begin
    t_strap(1'h1, 1'h1);
    t_csr();
    t_fifo();
    t_endian();
    t_irq();
    t_timer();
    t_wake();
    t_strap(1'h0, 1'h0);
    t_csr();
    close_out();
  end
endmodule
